// *** verilog/lcdcd_map.svh ***
// Purpose: constants of the lcd command decoder: opcodes, field positions, reset values, timing
// Assumes: 40 MHz core clock
// Notes: definitions only
`ifndef LCDCD_MAP_SVH
`define LCDCD_MAP_SVH
// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define LCDCD_CLK_MHZ 40
`define LCDCD_INIT_NS 1000
// least time, rounded up to whole cycles
`define LCDCD_INIT_CYC ((`LCDCD_INIT_NS * `LCDCD_CLK_MHZ + 999) / 1000)
// ------------------------------------------------------------
// command encodings
// ------------------------------------------------------------
`define LCDCD_OP_DISP 7'h57
`define LCDCD_OP_ADC 7'h50
`define LCDCD_OP_REV 7'h53
`define LCDCD_OP_BIAS 7'h51
`define LCDCD_OP_LINE 2'h1
`define LCDCD_OP_PAGE 4'hB
`define LCDCD_OP_COLH 4'h1
`define LCDCD_OP_COLL 4'h0
`define LCDCD_OP_SWRST 8'hE2
// ------------------------------------------------------------
// limits and status bit positions
// ------------------------------------------------------------
`define LCDCD_PAGE_IND 4'h8
`define LCDCD_COL_LAST 8'h83
`define LCDCD_ST_BUSY 7
`define LCDCD_ST_ADC 6
`define LCDCD_ST_OFF 5
`define LCDCD_ST_RST 4
// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define LCDCD_PWR_INIT 3'h0
`define LCDCD_BIAS_INIT 1'h0
`define LCDCD_LINE_INIT 6'h00
`define LCDCD_COL_INIT 8'h00
`define LCDCD_PAGE_INIT 4'h0
`define LCDCD_VOL_INIT 5'h00
`endif

// *** verilog/lcdcd_pkg.sv ***
// Purpose: types of the lcd command decoder
// Assumes: nothing
// Notes: constants live in lcdcd_map.svh
package lcdcd_pkg;
  // init sequencer, one-hot
  typedef enum logic [1:0] {
    LCDCD_RUN = 2'b01,
    LCDCD_INIT = 2'b10
  } lcdcd_state_t;
  // every software visible setting
  typedef struct packed {
    logic disp_on;
    logic rev;
    logic adc;
    logic rmw;
    logic [2:0] pwr;
    logic bias;
    logic ind;
    logic [5:0] line;
    logic [7:0] col;
    logic [3:0] page;
    logic ost3;
    logic [4:0] vol;
    logic test;
  } lcdcd_cfg_t;
endpackage

// *** verilog/lcdcd_fifo_if.sv ***
// Purpose: carrier between decoder and its write buffer
// Assumes: one clock
// Notes: user fills and drains, store is the buffer
`timescale 1ns/100ps
interface lcdcd_fifo_if #(parameter int WIDTH = 20);
  logic in_valid;
  logic in_ready;
  logic [WIDTH-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [WIDTH-1:0] out_data;
  modport user (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
  modport store (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
endinterface

// *** verilog/lcdcd_fifo.sv ***
// Purpose: write buffer for display data, registered read side
// Assumes: one clock, synchronous active low reset
// Notes: holds DEPTH words plus one in the output register
`timescale 1ns/100ps
module lcdcd_fifo #(
  parameter int WIDTH = 20, // word width
  parameter int DEPTH = 8 // array depth, power of two
) (
  input wire logic clk, // core clock
  input wire logic resetn, // synchronous reset
  input wire logic flush, // drop all words
  lcdcd_fifo_if.store port // both sides
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH]; // storage
  logic [AW-1:0] wp, rp, next_wp, next_rp; // pointers
  logic [AW:0] cnt, next_cnt; // words in the array
  logic ov, next_ov; // output register holds a word
  logic [WIDTH-1:0] od, next_od; // output register
  logic push, load; // array write and array read

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  assign port.in_ready = (cnt != (AW+1)'(DEPTH));
  assign port.out_valid = ov;
  assign port.out_data = od;
  always_comb begin
    push = port.in_valid & port.in_ready;
    // refill the output register whenever it is free or being taken
    load = (cnt != '0) & (~ov | port.out_ready);
    next_wp = push ? wp + AW'(1) : wp;
    next_rp = load ? rp + AW'(1) : rp;
    next_cnt = cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};
    next_ov = load | (ov & ~port.out_ready);
    next_od = load ? mem[rp] : od;
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn || flush) begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
      ov <= 1'b0;
      od <= '0;
    end else begin
      wp <= next_wp;
      rp <= next_rp;
      cnt <= next_cnt;
      ov <= next_ov;
      od <= next_od;
    end
  end
  // storage has no reset, it is only read behind cnt
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp] <= port.in_data;
    end
  end
endmodule // lcdcd_fifo

// *** verilog/lcdcd_top.sv ***
// Purpose: host command decoder and reset logic of a dot-matrix lcd driver
// Assumes: host pins synchronous to clk; ram side takes words on ram_we & ram_ready
// Notes: display data reads are not served; data write goes through a 9-word buffer, 8 array words plus the output register
// Operation
// - init pin low clears settings, serial shifter and write buffer, not the data pins
// - init: display off, normal, power zero
// - init selects the variant default bias
// - init: indicator off, line, column, page zero
// - init clears status D3, volume, test
// - init leaves oscillator and bus outputs alone
// - reset command applies items eight to fourteen
// - classify transfer by select and strobes
// - strobe style selects read or write
// - display command sets display from D0
// - start line command loads six bits
// - page command loads 0 to 8
// - column set by two nibble commands
// - column advances per access, page unchanged
// - status read returns busy, rejects when busy
// - segment order bit high when reversed
// - display bit reads high when off
// - reset flag high during initialization
// - data write stores byte then advances
`timescale 1ns/100ps
`include "lcdcd_map.svh"
module lcdcd_top (
  input wire logic clk, // 40 MHz core clock
  input wire logic resetn, // synchronous reset, low active
  input wire logic chip_init_n, // initialization pin, low active
  input wire logic strobe_mode, // 1 enable-strobe style, 0 separate strobes
  input wire logic serial_sel, // 1 serial input selected
  input wire logic cmd_data_select, // 0 command or status, 1 display data
  input wire logic rd_n_en, // read strobe, or enable
  input wire logic wr_n_rw, // write strobe, or read/write
  input wire logic [7:0] bus_din, // data pins, input side
  input wire logic ser_clk, // serial shift clock pin
  input wire logic ser_din, // serial data pin
  input wire logic ram_ready, // display ram takes a word
  output logic [7:0] bus_dout, // data pins, output side
  output logic bus_doe, // data pins driven
  output logic ram_we, // buffered write valid
  output logic [3:0] ram_page, // write page
  output logic [7:0] ram_col, // write column
  output logic [7:0] ram_wdata, // write byte
  output logic display_on, // display enabled
  output logic reverse_display, // inverted display
  output logic adc_reverse, // reversed segment order
  output logic rmw_on, // read-modify-write mode
  output logic [2:0] power_ctrl, // power control field
  output logic bias_sel, // 0 variant default bias
  output logic static_ind, // static indicator on
  output logic [5:0] start_line, // first_common_row line
  output logic out_status_d3, // output status bit D3
  output logic [4:0] volume, // electronic volume
  output logic test_mode, // test mode
  output logic busy // busy flag
);
  localparam lcdcd_pkg::lcdcd_cfg_t CFG_INIT = '{disp_on: 1'b0, rev: 1'b0, adc: 1'b0, rmw: 1'b0,
    pwr: `LCDCD_PWR_INIT, bias: `LCDCD_BIAS_INIT, ind: 1'b0, line: `LCDCD_LINE_INIT,
    col: `LCDCD_COL_INIT, page: `LCDCD_PAGE_INIT, ost3: 1'b0, vol: `LCDCD_VOL_INIT, test: 1'b0};
  localparam logic [7:0] INIT_CYC = 8'(`LCDCD_INIT_CYC);

  lcdcd_fifo_if #(.WIDTH(20)) fif (); // decoder to ram buffer
  lcdcd_pkg::lcdcd_cfg_t cfg, next_cfg; // settings
  lcdcd_pkg::lcdcd_state_t state, next_state; // init sequencer
  logic [7:0] cnt, next_cnt; // init cycles left
  logic rd_q, wr_q, sclk_q; // previous pin levels
  logic [7:0] sh, next_sh; // serial shift register
  logic [2:0] bcnt, next_bcnt; // serial bits taken
  logic [7:0] next_dout; // status byte to drive
  logic next_doe, next_busy; // pin drive, busy copy
  logic busy_now; // commands refused
  logic xfer_ev, xfer_a0; // a write transfer completes
  logic [7:0] xfer_byte; // its byte
  logic cmd_ok, stat_rd; // accepted command, status read active

  // ------------------------------------------------------------
  // buffer instance
  // ------------------------------------------------------------
  // full buffer turns into busy; data writes made while it is full are dropped
  lcdcd_fifo #(.WIDTH(20), .DEPTH(8)) u_fifo (
    .clk(clk),
    .resetn(resetn),
    .flush(~chip_init_n),
    .port(fif)
  );
  assign fif.out_ready = ram_ready;
  assign ram_we = fif.out_valid;
  assign {ram_page, ram_col, ram_wdata} = fif.out_data;

  // ------------------------------------------------------------
  // transfer classification
  // ------------------------------------------------------------
  // pins are sampled synchronously, so edges come from the previous level
  always_comb begin
    busy_now = (state == lcdcd_pkg::LCDCD_INIT) | ~fif.in_ready;
    xfer_ev = 1'b0;
    xfer_a0 = cmd_data_select;
    xfer_byte = bus_din;
    stat_rd = 1'b0;
    if (serial_sel) begin
      // eighth rising shift edge closes the byte, msb came first
      xfer_ev = ~sclk_q & ser_clk & (bcnt == 3'h7);
      xfer_byte = {sh[6:0], ser_din};
    end else if (strobe_mode) begin
      // enable falls with read/write low: write; enable high with it high: read
      xfer_ev = rd_q & ~rd_n_en & ~wr_n_rw;
      stat_rd = rd_n_en & wr_n_rw & ~cmd_data_select;
    end else begin
      // write strobe rises: write; read strobe low: read
      xfer_ev = ~wr_q & wr_n_rw;
      stat_rd = ~rd_n_en & ~cmd_data_select;
    end
    cmd_ok = xfer_ev & ~xfer_a0 & ~busy_now;
  end

  // ------------------------------------------------------------
  // serial shift and pin history
  // ------------------------------------------------------------
  always_comb begin
    next_sh = sh;
    next_bcnt = bcnt;
    if (!chip_init_n) begin
      next_sh = 8'h00;
      next_bcnt = 3'h0;
    end else if (serial_sel && !sclk_q && ser_clk) begin
      next_sh = {sh[6:0], ser_din};
      next_bcnt = bcnt + 3'h1;
    end
  end
  always_ff @(posedge clk) begin
    if (!resetn) begin
      sh <= 8'h00;
      bcnt <= 3'h0;
      rd_q <= 1'b1;
      wr_q <= 1'b1;
      sclk_q <= 1'b0;
    end else begin
      sh <= next_sh;
      bcnt <= next_bcnt;
      rd_q <= rd_n_en;
      wr_q <= wr_n_rw;
      sclk_q <= ser_clk;
    end
  end

  // ------------------------------------------------------------
  // command execution and init sequencer
  // ------------------------------------------------------------
  always_comb begin
    next_cfg = cfg;
    next_state = state;
    next_cnt = cnt;
    fif.in_valid = 1'b0;
    fif.in_data = {cfg.page, cfg.col, xfer_byte};
    if (cfg.page == `LCDCD_PAGE_IND) begin
      fif.in_data = {cfg.page, cfg.col, 7'h00, xfer_byte[0]};
    end
    if (!chip_init_n) begin
      // settings back to defaults, held while the pin stays low
      next_cfg = CFG_INIT;
      next_state = lcdcd_pkg::LCDCD_INIT;
      next_cnt = INIT_CYC;
    end else begin
      case (state)
        lcdcd_pkg::LCDCD_INIT: begin
          // internal timing only, no host clock involved
          next_cnt = cnt - 8'h01;
          if (cnt <= 8'h01) begin
            next_state = lcdcd_pkg::LCDCD_RUN;
          end
        end
        lcdcd_pkg::LCDCD_RUN: begin
          if (xfer_ev && xfer_a0 && !busy_now) begin
            // data: store at page and column, then step the column
            fif.in_valid = 1'b1;
            if (cfg.col < `LCDCD_COL_LAST) begin
              next_cfg.col = cfg.col + 8'h01;
            end
          end else if (cmd_ok) begin
            if (xfer_byte[7:1] == `LCDCD_OP_DISP) begin
              next_cfg.disp_on = xfer_byte[0];
            end else if (xfer_byte[7:1] == `LCDCD_OP_ADC) begin
              next_cfg.adc = xfer_byte[0];
            end else if (xfer_byte[7:1] == `LCDCD_OP_REV) begin
              next_cfg.rev = xfer_byte[0];
            end else if (xfer_byte[7:1] == `LCDCD_OP_BIAS) begin
              next_cfg.bias = xfer_byte[0];
            end else if (xfer_byte == `LCDCD_OP_SWRST) begin
              // only items eight to fourteen; display, power, bias kept
              next_cfg.ind = CFG_INIT.ind;
              next_cfg.line = CFG_INIT.line;
              next_cfg.col = CFG_INIT.col;
              next_cfg.page = CFG_INIT.page;
              next_cfg.ost3 = CFG_INIT.ost3;
              next_cfg.vol = CFG_INIT.vol;
              next_cfg.test = CFG_INIT.test;
              next_state = lcdcd_pkg::LCDCD_INIT;
              next_cnt = INIT_CYC;
            end else if (xfer_byte[7:6] == `LCDCD_OP_LINE) begin
              next_cfg.line = xfer_byte[5:0];
            end else if (xfer_byte[7:4] == `LCDCD_OP_PAGE) begin
              // pages above the indicator page are ignored
              if (xfer_byte[3:0] <= `LCDCD_PAGE_IND) begin
                next_cfg.page = xfer_byte[3:0];
              end
            end else if (xfer_byte[7:4] == `LCDCD_OP_COLH) begin
              next_cfg.col = {xfer_byte[3:0], cfg.col[3:0]};
            end else if (xfer_byte[7:4] == `LCDCD_OP_COLL) begin
              next_cfg.col = {cfg.col[7:4], xfer_byte[3:0]};
            end
            // any other byte falls through untouched
          end
        end
        default: begin
          next_state = lcdcd_pkg::LCDCD_INIT;
          next_cnt = INIT_CYC;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // status read path
  // ------------------------------------------------------------
  // the init pin does not touch the data pins, only resetn does
  always_comb begin
    next_doe = stat_rd & ~serial_sel;
    next_dout = bus_dout;
    next_busy = next_state == lcdcd_pkg::LCDCD_INIT;
    if (stat_rd && !serial_sel) begin
      next_dout = 8'h00;
      next_dout[`LCDCD_ST_BUSY] = busy_now;
      next_dout[`LCDCD_ST_ADC] = cfg.adc;
      next_dout[`LCDCD_ST_OFF] = ~cfg.disp_on;
      next_dout[`LCDCD_ST_RST] = state == lcdcd_pkg::LCDCD_INIT;
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cfg <= CFG_INIT;
      state <= lcdcd_pkg::LCDCD_INIT;
      cnt <= INIT_CYC;
      bus_dout <= 8'h00;
      bus_doe <= 1'b0;
      busy <= 1'b1;
    end else begin
      cfg <= next_cfg;
      state <= next_state;
      cnt <= next_cnt;
      bus_dout <= next_dout;
      bus_doe <= next_doe;
      busy <= next_busy | ~fif.in_ready;
    end
  end
  assign display_on = cfg.disp_on;
  assign reverse_display = cfg.rev;
  assign adc_reverse = cfg.adc;
  assign rmw_on = cfg.rmw;
  assign power_ctrl = cfg.pwr;
  assign bias_sel = cfg.bias;
  assign static_ind = cfg.ind;
  assign start_line = cfg.line;
  assign out_status_d3 = cfg.ost3;
  assign volume = cfg.vol;
  assign test_mode = cfg.test;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  localparam int A_INIT_MAX = `LCDCD_INIT_CYC + 2;
  default clocking a_cb @(posedge clk); endclocking
  default disable iff (!resetn);
  a_init_display: assert property (!chip_init_n |=> !display_on && !reverse_display
    && !adc_reverse && !rmw_on && power_ctrl == 3'h0) else $error("init display defaults wrong");
  a_init_bias: assert property (!chip_init_n |=> bias_sel == `LCDCD_BIAS_INIT)
    else $error("init bias wrong");
  a_init_address: assert property (!chip_init_n |=> !static_ind && start_line == 6'h00
    && cfg.col == 8'h00 && cfg.page == 4'h0) else $error("init address wrong");
  a_init_misc: assert property (!chip_init_n |=> !out_status_d3 && volume == 5'h00
    && !test_mode) else $error("init volume or test wrong");
  a_init_release: assert property ($rose(chip_init_n) |-> ##[1:A_INIT_MAX] !busy)
    else $error("init does not end in time");
  a_swrst_keeps: assert property (chip_init_n && cmd_ok && xfer_byte == `LCDCD_OP_SWRST
    |=> display_on == $past(display_on) && cfg.page == 4'h0 && busy) else $error("soft reset wrong");
  a_disp_cmd: assert property (chip_init_n && cmd_ok && xfer_byte[7:1] == `LCDCD_OP_DISP
    |=> display_on == $past(xfer_byte[0])) else $error("display command not applied");
  a_line_cmd: assert property (chip_init_n && cmd_ok && xfer_byte[7:6] == `LCDCD_OP_LINE
    |=> start_line == $past(xfer_byte[5:0])) else $error("start line not loaded");
  a_col_step: assert property (chip_init_n && fif.in_valid && cfg.col < `LCDCD_COL_LAST
    |=> cfg.col == $past(cfg.col) + 8'h01 && $stable(cfg.page)) else $error("column not stepped");
  a_status_bits: assert property (stat_rd && !serial_sel |=> bus_doe
    && bus_dout[5] == !display_on && bus_dout[3:0] == 4'h0) else $error("status byte wrong");
  a_busy_reject: assert property (chip_init_n && xfer_ev && busy_now
    |=> $stable(cfg.line) && $stable(cfg.disp_on)) else $error("command taken while busy");
  a_unknown_cmd: assert property (chip_init_n && cmd_ok && xfer_byte == 8'hFF
    |=> $stable(cfg) && state == lcdcd_pkg::LCDCD_RUN) else $error("unknown command acted");
  c_soft_reset: cover property (cmd_ok && xfer_byte == `LCDCD_OP_SWRST);
  c_page_ind: cover property (fif.in_valid && cfg.page == `LCDCD_PAGE_IND);
  c_buffer_full: cover property (!fif.in_ready ##1 fif.in_ready);
endmodule // lcdcd_top

// *** verif/lcdcd_ram_model.sv ***
// Purpose: display ram side model that takes buffered write words
// Assumes: one clock, word taken on ram_we and ram_ready at an edge
// Notes: stall holds ram_ready low so the write buffer backs up
`timescale 1ns/100ps
// ------------------------------------------------------------
// ram sink
// ------------------------------------------------------------
module lcdcd_ram_model (
  input wire logic clk, // core clock
  input wire logic resetn, // synchronous reset, low active
  input wire logic stall, // bench asks the ram to stall
  input wire logic ram_we, // word offered
  input wire logic [3:0] ram_page, // word page
  input wire logic [7:0] ram_col, // word column
  input wire logic [7:0] ram_wdata, // word byte
  output logic ram_ready // ram takes the word
);
  logic [19:0] got[$]; // words taken, page, column, byte
  // ready is a plain level, so a stalled ram never takes a word late
  assign ram_ready = ~stall;
  // take the word at the edge where both sides agree
  always @(posedge clk) begin
    if (resetn && ram_we && ram_ready) begin
      got.push_back({ram_page, ram_col, ram_wdata});
    end
  end
endmodule // lcdcd_ram_model

// *** verif/lcd_command_decoder_test.sv ***
// Purpose: self-checking bench of the lcd command decoder
// Assumes: separate-strobe host unless a test switches style
// Notes: expected values come from the command encodings only
`timescale 1ns/100ps
`define CHECK(g, e) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
  $display("BAD t=%0t got %h exp %h", $time, g, e); end end
module lcd_command_decoder_test;
  logic clk, resetn, chip_init_n, strobe_mode, serial_sel, cmd_data_select; // host levels
  logic rd_n_en, wr_n_rw, ser_clk, ser_din, stall, ram_ready; // strobes and ram side
  logic [7:0] bus_din, bus_dout, ram_col, ram_wdata; // bytes
  logic bus_doe, ram_we, display_on, reverse_display, adc_reverse, rmw_on, bias_sel; // flags
  logic static_ind, out_status_d3, test_mode, busy; // more flags
  logic [3:0] ram_page; // page of word
  logic [2:0] power_ctrl; // power field
  logic [5:0] start_line; // first line
  logic [4:0] volume; // volume field
  int fail_count, n_compared; // counters
  lcdcd_top dut (.clk(clk), .resetn(resetn), .chip_init_n(chip_init_n), .strobe_mode(strobe_mode),
    .serial_sel(serial_sel), .cmd_data_select(cmd_data_select), .rd_n_en(rd_n_en), .wr_n_rw(wr_n_rw),
    .bus_din(bus_din), .ser_clk(ser_clk), .ser_din(ser_din), .ram_ready(ram_ready), .bus_dout(bus_dout),
    .bus_doe(bus_doe), .ram_we(ram_we), .ram_page(ram_page), .ram_col(ram_col), .ram_wdata(ram_wdata),
    .display_on(display_on), .reverse_display(reverse_display), .adc_reverse(adc_reverse),
    .rmw_on(rmw_on), .power_ctrl(power_ctrl), .bias_sel(bias_sel), .static_ind(static_ind),
    .start_line(start_line), .out_status_d3(out_status_d3), .volume(volume), .test_mode(test_mode),
    .busy(busy));
  lcdcd_ram_model ram (.clk(clk), .resetn(resetn), .stall(stall), .ram_we(ram_we), .ram_page(ram_page),
    .ram_col(ram_col), .ram_wdata(ram_wdata), .ram_ready(ram_ready));
  // ------------------------------------------------------------
  // host access tasks
  // ------------------------------------------------------------
  // one write: strobe for one edge, released for the taking edge, one more edge to apply
  task automatic wr(input logic sel, input logic [7:0] b);
    @(posedge clk);
    cmd_data_select <= sel;
    bus_din <= b;
    // low write strobe, or read/write low for a write
    wr_n_rw <= 1'b0;
    if (strobe_mode) rd_n_en <= 1'b1;
    @(posedge clk);
    if (strobe_mode) rd_n_en <= 1'b0; else wr_n_rw <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
  endtask
  // status read, answer one edge after the taking edge
  task automatic rd(input logic [7:0] e);
    @(posedge clk);
    cmd_data_select <= 1'b0;
    // enable style reads with enable and read/write both high
    if (strobe_mode) wr_n_rw <= 1'b1;
    rd_n_en <= strobe_mode;
    repeat (2) @(posedge clk);
    #1;
    `CHECK(bus_doe, 1'b1)
    `CHECK(bus_dout, e)
    @(posedge clk);
    rd_n_en <= ~strobe_mode;
  endtask
  // serial byte, each clock phase held two edges
  task automatic ser(input logic [7:0] b);
    serial_sel <= 1'b1;
    for (int i = 7; i >= 0; i--) begin
      @(posedge clk);
      ser_din <= b[i];
      ser_clk <= 1'b0;
      repeat (2) @(posedge clk);
      ser_clk <= 1'b1;
      @(posedge clk);
    end
    @(posedge clk);
    ser_clk <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask
  // bounded wait for busy to drop
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 200) begin
      @(posedge clk);
      n++;
    end
    #1;
    `CHECK(busy, 1'b0)
  endtask
  // closing: counts, then verdict
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ------------------------------------------------------------
  // clock and watchdog
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // about 320 cycles are needed, so 5000 means a hang
  initial begin
    #(25 * 5000);
    fail_count++;
    tally_and_finish();
  end
  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    {resetn, chip_init_n, strobe_mode, serial_sel, cmd_data_select, ser_clk, ser_din, stall} = 8'h00;
    {rd_n_en, wr_n_rw} = 2'b11;
    bus_din = 8'h00;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    chip_init_n <= 1'b1;
    wait_idle();
    `CHECK({display_on, reverse_display, adc_reverse, rmw_on, power_ctrl}, 7'h00)
    `CHECK(bias_sel, 1'b0)
    `CHECK({static_ind, start_line}, 7'h00)
    `CHECK({out_status_d3, volume, test_mode}, 7'h00)
    rd(8'h20);
    wr(1'b0, 8'hAF);
    `CHECK(display_on, 1'b1)
    rd(8'h00);
    wr(1'b0, 8'hA1);
    rd(8'h40);
    wr(1'b0, 8'h7F);
    `CHECK(start_line, 6'h3F)
    // page 3, column 130 from two nibbles, then three bytes saturating at 131
    wr(1'b0, 8'hB3);
    wr(1'b0, 8'h18);
    wr(1'b0, 8'h02);
    wr(1'b1, 8'h5A);
    wr(1'b1, 8'hA5);
    wr(1'b1, 8'h3C);
    wr(1'b0, 8'hB9);
    wr(1'b0, 8'hB8);
    wr(1'b1, 8'hFF);
    repeat (4) @(posedge clk);
    #1;
    `CHECK(ram.got.size(), 4)
    `CHECK(ram.got[0], 20'h3825A)
    `CHECK(ram.got[1], 20'h383A5)
    `CHECK(ram.got[2], 20'h3833C)
    `CHECK(ram.got[3], 20'h88301)
    wr(1'b0, 8'hFF);
    `CHECK({display_on, adc_reverse, start_line}, 8'hFF)
    // reverse display and bias select, kept later by the soft reset
    wr(1'b0, 8'hA7);
    wr(1'b0, 8'hA3);
    `CHECK({reverse_display, bias_sel}, 2'b11)
    // soft reset, then a write that must be refused while busy
    wr(1'b0, 8'hE2);
    wr(1'b0, 8'h45);
    rd(8'hD0);
    wait_idle();
    `CHECK({display_on, adc_reverse, start_line}, 8'hC0)
    `CHECK({reverse_display, bias_sel}, 2'b11)
    rd(8'h40);
    // stalled ram: eight array words plus the output register, then refusals
    ram.got.delete();
    stall <= 1'b1;
    for (int i = 0; i < 12; i++) wr(1'b1, 8'h10 + 8'(i));
    `CHECK(busy, 1'b1)
    stall <= 1'b0;
    repeat (20) @(posedge clk);
    #1;
    `CHECK(ram.got.size(), 9)
    `CHECK(ram.got[0], 20'h00010)
    `CHECK(ram.got[8], 20'h00818)
    // enable-strobe style
    // enable falls with read/write high, so the style switch makes no false write
    strobe_mode <= 1'b1;
    {rd_n_en, wr_n_rw} <= 2'b01;
    wr(1'b0, 8'hAE);
    `CHECK(display_on, 1'b0)
    rd(8'h60);
    ser(8'hAF);
    `CHECK(display_on, 1'b1)
    // init pin: defaults while low, data pins left alone
    @(posedge clk);
    chip_init_n <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    `CHECK({display_on, adc_reverse, start_line, busy}, 9'h001)
    `CHECK({reverse_display, bias_sel}, 2'b00)
    `CHECK(bus_dout, 8'h60)
    chip_init_n <= 1'b1;
    wait_idle();
    tally_and_finish();
  end
endmodule // lcd_command_decoder_test
